// ===== logic/ats_regs.vh
// Functional notes
// - Frames stream out continuously at the 48 kHz frame rate, no request needed.
// - All link timing follows edges of the external bit clock.
// - Default: sync high selects right channel, sync low selects left.
// - The polarity swap bit reverses the sync level to channel mapping.
// - Every sync transition marks the boundary between frame halves.
// - With sync edge select cleared, sync is sampled on the rising bit clock edge.
// - Lead bit clear: MSB in the sync change cycle; set: one cycle later.
// - Sync edge select moves sync sampling to the falling bit clock edge.
// - Samples go out in two's complement, MSB first.
// - LSB sits 16 bits into a slot at either word length; a 32-bit slot pads with zeros.
// - Line use follows the two line enable bits and the format.
// - Formats: 32x2, 16x4 at low rate; 32x4, 16x8 at high rate.
// - The 32-bit two-slot format uses both lines, others use one.
// - Sample output and register port work independently and concurrently.
// - A frame lasts 64 bit clocks at low rate, 128 at high rate.
// - Slots one to three carry x, y, z; later slots are zero.
// - In single-line formats the unused line stays low all frame.
// - Two-slot format: line 0 carries x then y, line 1 z then zero.
`ifndef ATS_REGS_VH
`define ATS_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define ATS_ADDR_CFG_A   8'h81
`define ATS_ADDR_CFG_B   8'h82
`define ATS_ADDR_RATE    8'h83
`define ATS_ADDR_STAT    8'h8E

// ****************************************
// Field positions
// ****************************************
`define ATS_CFGA_SWAP    7
`define ATS_CFGA_LEAD    6
`define ATS_CFGA_W32     4
`define ATS_CFGB_EDGE    2
`define ATS_CFGB_ON1     1
`define ATS_CFGB_ON0     0
`define ATS_RATE_HI      0
`define ATS_STAT_RUN     0
`define ATS_STAT_EMPTY   1
`define ATS_STAT_FULL    2

// ****************************************
// Reset values and sizes
// ****************************************
`define ATS_CFGA_RST     8'h10
`define ATS_CFGB_RST     8'h03
`define ATS_RATE_RST     8'h00
`define ATS_FRAME_LO     8'h40
`define ATS_FRAME_HI     8'h80
`define ATS_CNT_MAX      8'hFF
`define ATS_SAMPLE_W     16
`define ATS_TRIO_W       48
`define ATS_FIFO_DEPTH   16
`define ATS_FIFO_AW      4
`define ATS_SLOT_X       3'h0
`define ATS_SLOT_Y       3'h1
`define ATS_SLOT_Z       3'h2
`define ATS_SLOT_NONE    3'h3
`define ATS_ST_HUNT      2'h1
`define ATS_ST_RUN       2'h2

`endif

// ===== logic/ats_fifo.v
`timescale 1ns/1ps
module ats_fifo #(
    parameter WIDTH = 48,
    parameter DEPTH = 16,
    parameter AW    = 4
)(
    input  wire             core_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire             full,
    output wire             empty
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_ff;
    reg [AW-1:0]    rd_ptr_ff;
    reg [AW:0]      count_ff;
    wire            push;
    wire            pop;

    // Flags straight from the fill count, so full really means no room
    assign full      = (count_ff == DEPTH[AW:0]);
    assign empty     = (count_ff == {(AW+1){1'b0}});
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign push      = in_valid & ~full;
    assign pop       = out_ready & ~empty;

    // Head word shown combinationally from storage
    always @*
    begin
        out_data = mem_ff[rd_ptr_ff];
    end

    // Storage write, no reset needed on data
    always @(posedge core_clk)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and count
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push & ~pop)
            begin
                count_ff <= count_ff + 1'b1;
            end
            else if (pop & ~push)
            begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

// ===== logic/ats_serial_out.v
`timescale 1ns/1ps
`include "ats_regs.vh"
module ats_serial_out (
    input  wire                     core_clk,
    input  wire                     rst,
    input  wire                     bclk,
    input  wire                     sync,
    input  wire [`ATS_SAMPLE_W-1:0] sample_x,
    input  wire [`ATS_SAMPLE_W-1:0] sample_y,
    input  wire [`ATS_SAMPLE_W-1:0] sample_z,
    input  wire                     sample_valid,
    output wire                     sample_ready,
    input  wire [7:0]               reg_addr,
    input  wire [7:0]               reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [7:0]               reg_rdata,
    output wire [1:0]               serial_out_lines
);
    // ****************************************
    // Declarations
    // ****************************************
    reg  [7:0]             cfg_a_ff;
    reg  [7:0]             cfg_b_ff;
    reg  [7:0]             rate_ff;
    reg  [7:0]             rdata_ff;
    reg                    bclk_m_ff;
    reg                    bclk_s_ff;
    reg                    bclk_d_ff;
    reg                    sync_m_ff;
    reg                    sync_s_ff;
    reg                    sync_q_ff;
    reg  [7:0]             cnt_ff;
    reg  [7:0]             nxt_cnt;
    reg  [1:0]             state_ff;
    reg  [1:0]             nxt_state;
    reg  [`ATS_TRIO_W-1:0] cur_ff;
    reg  [1:0]             lines_ff;
    reg  [1:0]             nxt_lines;
    reg  [7:0]             pos;
    reg  [2:0]             slot;
    reg  [4:0]             bidx;
    reg                    d0;
    reg                    d1;
    wire                   swap;
    wire                   lead;
    wire                   word32;
    wire                   rate_hi;
    wire                   edge_sel;
    wire                   on0;
    wire                   on1;
    wire                   dual;
    wire [7:0]             frame_len;
    wire                   bclk_rise;
    wire                   bclk_fall;
    wire                   samp_edge;
    wire                   launch_edge;
    wire                   first_lvl;
    wire                   frame_start;
    wire [`ATS_TRIO_W-1:0] fifo_dout;
    wire                   fifo_valid;
    wire                   fifo_pop;
    wire                   fifo_full;
    wire                   fifo_empty;
    wire [7:0]             status;
    wire                   wrap;
    wire                   take_trio;
    wire [`ATS_TRIO_W-1:0] trio_now;
    localparam [1:0]       ST_HUNT = `ATS_ST_HUNT;
    localparam [1:0]       ST_RUN  = `ATS_ST_RUN;

    // ****************************************
    // Helpers
    // ****************************************
    // Bit b (counted from the MSB) of one slot; 16-bit samples sit
    // left-justified, so a 32-bit slot carries zeros below bit 16
    function slot_bit;
        input [`ATS_TRIO_W-1:0] trio;
        input [2:0]             s;
        input [4:0]             b;
        reg   [15:0]            w;
        begin
            case (s)
                `ATS_SLOT_X: w = trio[47:32];
                `ATS_SLOT_Y: w = trio[31:16];
                `ATS_SLOT_Z: w = trio[15:0];
                default:     w = 16'h0000;
            endcase
            if (b[4])
                slot_bit = 1'b0;
            else
                slot_bit = w[4'hF - b[3:0]];
        end
    endfunction

    // ****************************************
    // Configuration fields
    // ****************************************
    assign swap      = cfg_a_ff[`ATS_CFGA_SWAP];
    assign lead      = cfg_a_ff[`ATS_CFGA_LEAD];
    assign word32    = cfg_a_ff[`ATS_CFGA_W32];
    assign edge_sel  = cfg_b_ff[`ATS_CFGB_EDGE];
    assign on0       = cfg_b_ff[`ATS_CFGB_ON0];
    assign on1       = cfg_b_ff[`ATS_CFGB_ON1];
    // Rate register trusted as the real clock; no frequency check here
    assign rate_hi   = rate_ff[`ATS_RATE_HI];
    // Format follows rate and word length together
    assign dual      = word32 & ~rate_hi;
    assign frame_len = rate_hi ? `ATS_FRAME_HI : `ATS_FRAME_LO;
    assign status    = {5'h00, fifo_full, fifo_empty, state_ff[1]};

    // ****************************************
    // Register port
    // ****************************************
    // Runs on the core clock, fully apart from the link logic
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            cfg_a_ff <= `ATS_CFGA_RST;
            cfg_b_ff <= `ATS_CFGB_RST;
            rate_ff  <= `ATS_RATE_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `ATS_ADDR_CFG_A: cfg_a_ff <= reg_wdata;
                `ATS_ADDR_CFG_B: cfg_b_ff <= reg_wdata;
                `ATS_ADDR_RATE:  rate_ff <= reg_wdata;
                default:         cfg_a_ff <= cfg_a_ff;
            endcase
        end
    end

    // Read data held in a flop; unmapped offsets read zero
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            rdata_ff <= 8'h00;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `ATS_ADDR_CFG_A: rdata_ff <= cfg_a_ff;
                `ATS_ADDR_CFG_B: rdata_ff <= cfg_b_ff;
                `ATS_ADDR_RATE:  rdata_ff <= rate_ff;
                `ATS_ADDR_STAT:  rdata_ff <= status;
                default:         rdata_ff <= 8'h00;
            endcase
        end
    end

    always @*
    begin
        reg_rdata = rdata_ff;
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Two flops per pin; the third bclk flop only feeds the edge detect
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            bclk_m_ff <= 1'b0;
            bclk_s_ff <= 1'b0;
            bclk_d_ff <= 1'b0;
            sync_m_ff <= 1'b0;
            sync_s_ff <= 1'b0;
        end
        else
        begin
            bclk_m_ff <= bclk;
            bclk_s_ff <= bclk_m_ff;
            bclk_d_ff <= bclk_s_ff;
            sync_m_ff <= sync;
            sync_s_ff <= sync_m_ff;
        end
    end

    // Every link action waits for a bit clock edge; no local timebase
    assign bclk_rise   = bclk_s_ff & ~bclk_d_ff;
    assign bclk_fall   = ~bclk_s_ff & bclk_d_ff;
    // Sync taken on the rising edge unless edge select picks falling
    assign samp_edge   = edge_sel ? bclk_fall : bclk_rise;
    assign launch_edge = edge_sel ? bclk_rise : bclk_fall;
    // Left channel is the first half; swap flips which level that is
    assign first_lvl   = swap;
    // Change into the first-half level opens a frame
    assign frame_start = samp_edge & (sync_s_ff != sync_q_ff)
                         & (sync_s_ff == first_lvl);

    // ****************************************
    // Frame tracking
    // ****************************************
    // Hunt until a frame opens; a frame running past its length drops
    // back to hunt so a lost sync cannot leave stale slots on the lines
    always @*
    begin
        nxt_cnt   = cnt_ff;
        nxt_state = state_ff;
        if (frame_start)
        begin
            nxt_cnt   = 8'h00;
            nxt_state = ST_RUN;
        end
        else if (samp_edge)
        begin
            if (cnt_ff != `ATS_CNT_MAX)
                nxt_cnt = cnt_ff + 8'h01;
            case (state_ff)
                ST_RUN:
                begin
                    if (cnt_ff >= frame_len - 8'h01)
                        nxt_state = ST_HUNT;
                end
                default: nxt_state = ST_HUNT;
            endcase
        end
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            sync_q_ff <= 1'b0;
            cnt_ff    <= `ATS_CNT_MAX;
            state_ff  <= ST_HUNT;
        end
        else
        begin
            if (samp_edge)
            begin
                sync_q_ff <= sync_s_ff;
            end
            cnt_ff   <= nxt_cnt;
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Sample capture
    // ****************************************
    // Launch edge that closes a running frame already carries the next MSB unless the lead bit is set
    assign wrap      = launch_edge & state_ff[1] & (cnt_ff == frame_len - 8'h01);
    // One trio taken per frame as its first bit leaves, or at the first
    // opening after a hunt; with the FIFO empty the last trio repeats
    // rather than tearing a frame apart
    assign take_trio = wrap | (frame_start & ~state_ff[1]);
    assign fifo_pop  = take_trio & fifo_valid;
    // The first bit must come from the trio that is loaded at that same edge
    assign trio_now  = (wrap & fifo_valid) ? fifo_dout : cur_ff;

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            cur_ff <= {`ATS_TRIO_W{1'b0}};
        end
        else if (fifo_pop)
        begin
            cur_ff <= fifo_dout;
        end
    end

    ats_fifo #(
        .WIDTH (`ATS_TRIO_W),
        .DEPTH (`ATS_FIFO_DEPTH),
        .AW    (`ATS_FIFO_AW)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_data   ({sample_x, sample_y, sample_z}),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_dout),
        .out_valid (fifo_valid),
        .out_ready (take_trio),
        .full      (fifo_full),
        .empty     (fifo_empty)
    );

    // ****************************************
    // Serialiser
    // ****************************************
    // Position of the bit that leaves on the coming launch edge; the MSB is
    // predicted from the count so it shares the cycle of the sync change,
    // and the lead bit pushes it one cycle later (wrap then lands on zeros)
    always @*
    begin
        pos  = (wrap ? 8'h00 : cnt_ff + 8'h01) - {7'h00, lead};
        slot = word32 ? {1'b0, pos[6:5]} : pos[6:4];
        bidx = word32 ? pos[4:0] : {1'b0, pos[3:0]};
        d0   = slot_bit(trio_now, slot, bidx);
        d1   = slot_bit(trio_now, (slot == `ATS_SLOT_X) ? `ATS_SLOT_Z : `ATS_SLOT_NONE, bidx);
        nxt_lines = 2'b00;
        if (state_ff[1])
        begin
            if (dual)
            begin
                nxt_lines = {on1 & d1, on0 & d0};
            end
            else if (on0)
            begin
                nxt_lines = {1'b0, d0};
            end
            else
            begin
                nxt_lines = {on1 & d0, 1'b0};
            end
        end
    end

    // Lines change on the edge opposite the sync sampling edge
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            lines_ff <= 2'b00;
        end
        else if (launch_edge)
        begin
            lines_ff <= nxt_lines;
        end
    end

    assign serial_out_lines = lines_ff;
endmodule

// ===== dv/ats_host_model.sv
`timescale 1ns/1ps
// ****
// Host end of the link: bit clock, sync, data capture
// ****
module ats_host_model (
    input  wire [7:0]   frame_len,
    input  wire         swap,
    input  wire         edge_fall,
    input  wire [1:0]   serial_out_lines,
    output reg          bclk,
    output reg          sync,
    output reg  [127:0] last0,
    output reg  [127:0] last1,
    output reg  [31:0]  frames
);
    reg [127:0] cap0;
    reg [127:0] cap1;
    integer     k;
    // Bit clock runs free, also while registers are accessed
    initial
    begin
        bclk = 1'b0;
        sync = 1'b0;
        k = 0;
        frames = 32'h0;
        cap0 = 128'h0;
        cap1 = 128'h0;
        last0 = 128'h0;
        last1 = 128'h0;
        forever
        begin
            #400;
            bclk = ~bclk;
            if (bclk == edge_fall)
            begin
                // Sync moves on the edge the device does not sample
                k = (k + 1) % frame_len;
                sync = swap ^ (k >= frame_len / 2);
            end
            else
            begin
                // Bit launched with the last sync update is settled here
                cap0[k] = serial_out_lines[0];
                cap1[k] = serial_out_lines[1];
                if (k == frame_len - 1)
                begin
                    last0 = cap0;
                    last1 = cap1;
                    frames = frames + 32'h1;
                end
            end
        end
    end
endmodule

// ===== dv/ats_serial_out_sva.sv
`timescale 1ns/1ps
`include "ats_regs.vh"
// ****
// Port checks for the serial output block
// ****
module ats_serial_out_sva (
    input wire       core_clk,
    input wire       rst,
    input wire       sample_valid,
    input wire       sample_ready,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire [1:0] serial_out_lines
);
    reg [7:0] shadow_a_ff;
    reg [7:0] shadow_b_ff;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // Last written format values, so read-back can be judged
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            shadow_a_ff <= `ATS_CFGA_RST;
            shadow_b_ff <= `ATS_CFGB_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `ATS_ADDR_CFG_A)
                shadow_a_ff <= reg_wdata;
            if (reg_addr == `ATS_ADDR_CFG_B)
                shadow_b_ff <= reg_wdata;
        end
    end
    property p_rst_quiet; $fell(rst) |-> (serial_out_lines == 2'h0) [*4]; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("lines active after reset");
    property p_rst_idle; $fell(rst) |-> sample_ready && reg_rdata == 8'h00; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("bad idle after reset");
    property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_unmapped;
        reg_rd && !(reg_addr inside {`ATS_ADDR_CFG_A, `ATS_ADDR_CFG_B, `ATS_ADDR_RATE, `ATS_ADDR_STAT})
        |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_cfga_back; reg_rd && reg_addr == `ATS_ADDR_CFG_A |=> (reg_rdata & 8'hD0) == ($past(shadow_a_ff) & 8'hD0); endproperty
    a_cfga_back: assert property (p_cfga_back) else $error("format a read-back");
    property p_cfgb_back; reg_rd && reg_addr == `ATS_ADDR_CFG_B |=> reg_rdata[2:0] == $past(shadow_b_ff[2:0]); endproperty
    a_cfgb_back: assert property (p_cfgb_back) else $error("format b read-back");
    property p_stat_full; reg_rd && reg_addr == `ATS_ADDR_STAT |=> reg_rdata[2] == !$past(sample_ready); endproperty
    a_stat_full: assert property (p_stat_full) else $error("full flag wrong");
    property p_ready_fall; $fell(sample_ready) |-> $past(sample_valid); endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready fell without push");
    property p_bit_hold; $changed(serial_out_lines) |=> $stable(serial_out_lines) [*3]; endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("line bit too short");
    c_full: cover property ($fell(sample_ready));
    c_dual: cover property (serial_out_lines == 2'h3);
    c_stat: cover property (reg_rd && reg_addr == `ATS_ADDR_STAT ##1 reg_rdata[2]);
endmodule

// ===== dv/accel_tdm_serial_output_bench.sv
`timescale 1ns/1ps
`include "ats_regs.vh"
module accel_tdm_serial_output_bench;
    reg          core_clk, rst, sample_valid, reg_wr, reg_rd, swap, edge_fall;
    reg  [15:0]  sample_x, sample_y, sample_z;
    reg  [7:0]   reg_addr, reg_wdata, frame_len, cfg_a, cfg_b, rate, rd_val;
    wire         bclk, sync, sample_ready;
    wire [7:0]   reg_rdata;
    wire [1:0]   serial_out_lines;
    wire [127:0] last0, last1;
    wire [31:0]  frames;
    integer      failures, checked;
    ats_serial_out dut_u (.core_clk(core_clk), .rst(rst), .bclk(bclk), .sync(sync), .sample_x(sample_x),
        .sample_y(sample_y), .sample_z(sample_z), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_out_lines(serial_out_lines));
    ats_host_model host_u (.frame_len(frame_len), .swap(swap), .edge_fall(edge_fall), .bclk(bclk), .sync(sync),
        .serial_out_lines(serial_out_lines), .last0(last0), .last1(last1), .frames(frames));
    // ****
    // Shared tasks
    // ****
    task check(input [127:0] seen, want);
        begin
            checked = checked + 1;
            if (seen !== want)
            begin
                failures = failures + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task wr(input [7:0] a, d);
        begin
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge core_clk);
            reg_wr = 1'b0;
            @(negedge core_clk);
        end
    endtask
    task rd(input [7:0] a, output [7:0] v);
        begin
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge core_clk);
            reg_rd = 1'b0;
            @(negedge core_clk);
            v = reg_rdata;
        end
    endtask
    // One trio per push; spare edge so valid is never set twice at once
    task push(input [15:0] x, y, z);
        integer n;
        begin
            n = 0;
            while (sample_ready !== 1'b1 && n < 2000)
            begin
                @(negedge core_clk);
                n = n + 1;
            end
            {sample_x, sample_y, sample_z} = {x, y, z};
            sample_valid = 1'b1;
            @(negedge core_clk);
            sample_valid = 1'b0;
            @(negedge core_clk);
        end
    endtask
    task wait_frames(input integer n);
        repeat (n) @(frames);
    endtask
    // Three frames let the device hunt and lock after any change
    task set_cfg(input [7:0] a, b, r, n, input s, e);
        begin
            @(negedge core_clk);
            wr(`ATS_ADDR_CFG_A, a);
            wr(`ATS_ADDR_CFG_B, b);
            wr(`ATS_ADDR_RATE, r);
            {cfg_a, cfg_b, rate, frame_len, swap, edge_fall} = {a, b, r, n, s, e};
            wait_frames(3);
        end
    endtask
    function [127:0] exp_line(input integer ln, input [15:0] x, y, z);
        integer j, p, s, b, sw;
        reg [15:0] v;
        reg        dual;
        begin
            exp_line = 128'h0;
            dual = !rate[0] && cfg_a[4];
            sw = cfg_a[4] ? 32 : 16;
            for (j = 0; j < frame_len; j = j + 1)
            begin
                p = j - (cfg_a[6] ? 1 : 0);
                s = p / sw + ((dual && ln == 1) ? 2 : 0);
                b = p % sw;
                v = (s == 0) ? x : (s == 1) ? y : (s == 2) ? z : 16'h0;
                if (p >= 0 && b < 16 && (dual ? cfg_b[ln] : (ln == (cfg_b[0] ? 0 : 1) && cfg_b[ln])))
                    exp_line[j] = v[15 - b];
            end
        end
    endfunction
    task check_frame(input [15:0] x, y, z);
        reg [127:0] msk;
        begin
            msk = {128{1'b1}} >> (8'h80 - frame_len);
            check(last0 & msk, exp_line(0, x, y, z));
            check(last1 & msk, exp_line(1, x, y, z));
        end
    endtask
    // ****
    // Scenarios
    // ****
    task t_regs;
        begin
            rd(`ATS_ADDR_CFG_A, rd_val);
            check(rd_val, `ATS_CFGA_RST);
            rd(`ATS_ADDR_CFG_B, rd_val);
            check(rd_val, `ATS_CFGB_RST);
            rd(`ATS_ADDR_RATE, rd_val);
            check(rd_val, `ATS_RATE_RST);
            wr(8'h90, 8'h5A);
            wr(`ATS_ADDR_STAT, 8'hFF);
            rd(8'h90, rd_val);
            check(rd_val, 8'h00);
            rd(`ATS_ADDR_STAT, rd_val);
            check(rd_val & 8'h06, 8'h02);
        end
    endtask
    task t_formats;
        integer f;
        begin
            for (f = 0; f < 4; f = f + 1)
            begin
                push(16'h8001, 16'h7FFE, 16'hC35A);
                set_cfg({3'h0, f[0], 4'h0}, 8'h03, {7'h0, f[1]}, f[1] ? 8'h80 : 8'h40, 1'b0, 1'b0);
                check_frame(16'h8001, 16'h7FFE, 16'hC35A);
            end
        end
    endtask
    task t_options;
        begin
            set_cfg(8'h50, 8'h03, 8'h00, 8'h40, 1'b0, 1'b0);
            check_frame(16'h8001, 16'h7FFE, 16'hC35A);
            set_cfg(8'hD0, 8'h03, 8'h00, 8'h40, 1'b1, 1'b0);
            check_frame(16'h8001, 16'h7FFE, 16'hC35A);
            set_cfg(8'h90, 8'h07, 8'h00, 8'h40, 1'b1, 1'b1);
            check_frame(16'h8001, 16'h7FFE, 16'hC35A);
        end
    endtask
    task t_enables;
        integer i;
        reg [9:0] enc;
        begin
            enc = 10'h0E9;
            for (i = 0; i < 5; i = i + 1)
            begin
                set_cfg(i < 2 ? 8'h10 : 8'h00, {6'h0, enc[2 * i +: 2]}, 8'h00, 8'h40, 1'b0, 1'b0);
                check_frame(16'h8001, 16'h7FFE, 16'hC35A);
            end
        end
    endtask
    // Fill right after an opening, then one trio drains per frame
    task t_fifo;
        integer i;
        begin
            set_cfg(8'h10, 8'h03, 8'h00, 8'h40, 1'b0, 1'b0);
            wait_frames(1);
            repeat (10) @(negedge core_clk);
            for (i = 0; i < 16; i = i + 1)
                push({12'hA50, i[3:0]}, {12'h5A0, i[3:0]}, {12'hC30, i[3:0]});
            check(sample_ready, 1'b0);
            rd(`ATS_ADDR_STAT, rd_val);
            check(rd_val & 8'h04, 8'h04);
            wait_frames(1);
            for (i = 0; i < 17; i = i + 1)
            begin
                wait_frames(1);
                check_frame({12'hA50, i > 15 ? 4'hF : i[3:0]}, {12'h5A0, i > 15 ? 4'hF : i[3:0]},
                    {12'hC30, i > 15 ? 4'hF : i[3:0]});
            end
            @(negedge core_clk);
            rd(`ATS_ADDR_STAT, rd_val);
            check(rd_val & 8'h06, 8'h02);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checked %0d failures %0d", checked, failures);
            if (failures == 0 && checked > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // 10 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Cut a hang well past the expected run of about 3 ms
    initial
    begin
        #8000000;
        failures = failures + 1;
        tally_and_finish;
    end
    // Main sequence
    initial
    begin
        {failures, checked} = {32'h0, 32'h0};
        {rst, sample_valid, reg_wr, reg_rd, swap, edge_fall} = 6'h20;
        {sample_x, sample_y, sample_z, reg_addr, reg_wdata} = 64'h0;
        {cfg_a, cfg_b, rate, frame_len} = {`ATS_CFGA_RST, `ATS_CFGB_RST, `ATS_RATE_RST, 8'h40};
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        t_regs;
        t_formats;
        t_options;
        t_enables;
        t_fifo;
        tally_and_finish;
    end
endmodule
bind ats_serial_out ats_serial_out_sva chk_u (.core_clk(core_clk), .rst(rst), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_out_lines(serial_out_lines));
